/* common/fsg_pkg.sv */
// Package for the flash security guard: address map, keys, codes, types.
// Assumes a 16-bit byte address space with 1024-byte pages.
package fsg_pkg;
  localparam logic [15:0] LOCK_BYTE_ADDR   = 16'hfbff;
  localparam logic [15:0] PART_ID_ADDR     = 16'hfffe;
  localparam logic [15:0] RESERVED_BASE    = 16'hfc00;
  localparam logic [15:0] SCRATCH_LAST     = 16'h03ff;
  localparam int          PAGE_MSB         = 15;
  localparam int          PAGE_LSB         = 10;
  localparam logic [5:0]  LOCK_PAGE_IDX    = 6'h3e;
  localparam logic [7:0]  KEY_FIRST        = 8'ha5;
  localparam logic [7:0]  KEY_SECOND       = 8'hf1;
  localparam logic [7:0]  LOCK_BYTE_ERASED = 8'hff;
  // Arbitrary neutral part code
  localparam logic [7:0]  PART_ID_CODE     = 8'h5a;
  localparam logic        SUPPLY_MON_RST   = 1'b1;
  localparam logic        SUPPLY_SRC_RST   = 1'b1;
  localparam logic        FLASH_ERR_RST    = 1'b0;

  typedef enum logic [1:0] {
    FSG_OP_READ  = 2'h0,
    FSG_OP_WRITE = 2'h1,
    FSG_OP_ERASE = 2'h2,
    FSG_OP_FETCH = 2'h3
  } fsg_op_t;

  // One access request from firmware or debug port
  typedef struct packed {
    logic        valid;
    logic        from_debug;
    logic        code_move;
    fsg_op_t     op;
    logic [15:0] addr;
    logic [15:0] pc;
  } fsg_req_t;

  // Verdict for one access
  typedef struct packed {
    logic        done;
    logic        permit;
    logic        to_flash;
    logic        to_scratch;
    logic        to_external_data_ram;
    logic        ignored;
  } fsg_resp_t;
endpackage : fsg_pkg

/* design/fsg_guard.sv */
// Flash security guard: judges each flash access, drives error reset.
// Assumes the lock byte value is supplied by the flash array at reset.
// Operation
// - Scratchpad select maps 1024-byte scratchpad at 0x0000-0x03FF instead of flash.
// - Firmware instruction fetches never come from the scratchpad.
// - Firmware flash read only by code-memory move; its external-data reads go to data RAM.
// - Write needs write enable; erase needs write and erase enables.
// - Lock byte complement gives n locked pages from page 0.
// - Lock byte page locked whenever any lock byte bit is zero.
// - Prohibited debug accesses are ignored, no reset.
// - Prohibited firmware access resets device and sets flash error flag.
// - Locked pages open to locked-page firmware only.
// - Lock page and lock byte reads protected when any page locked.
// - Firmware erase of lock page resets; debug may erase it if unlocked.
// - Written lock byte cannot change except by full device erase.
// - Debug full erase clears all pages and unlocks everything.
// - Reserved area refused from debug, resets from firmware except fetches, which pass to flash.
// - New lock byte takes effect only after next reset sample.
// - Scratchpad locked when all pages locked; erased by full erase.
// - Read-only part code readable at 0xFFFE.
// - Write or erase with supply monitor or its reset source off resets.
// - Supply monitor and its reset enable set after power-on reset.
// - Execution stalls during flash operation.
// - Keys 0xA5 then 0xF1 arm one write or erase; bad key disables.
module fsg_guard (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               por_rst,
  // Control bits
  input  wire logic               scratchpad_select,
  input  wire logic               program_write_enable,
  input  wire logic               program_erase_enable,
  input  wire logic               supply_mon_clr,
  input  wire logic               supply_src_clr,
  input  wire logic               key_wr,
  input  wire logic [7:0]         key_data,
  input  wire logic               flash_error_clr,
  // Flash array state
  input  wire logic [7:0]         lock_byte_in,
  input  wire logic               flash_busy,
  input  wire logic               debug_full_erase,
  // Access
  input  wire fsg_pkg::fsg_req_t  req,
  output fsg_pkg::fsg_resp_t      resp,
  output logic [7:0]              part_id,
  output logic                    flash_error_reset,
  output logic                    flash_error_flag,
  output logic                    cpu_stall,
  output logic                    supply_mon_en,
  output logic                    supply_src_en,
  output logic                    key_armed,
  output logic [7:0]              lock_count
);
  // ===========================================================
  // Lock state sampled at reset
  logic [7:0] lock_n_r, lock_n_nxt;
  logic       sampled_r, sampled_nxt;
  always_comb begin
    lock_n_nxt  = lock_n_r;
    sampled_nxt = 1'b1;
    if (!sampled_r) begin
      lock_n_nxt = ~lock_byte_in;
    end
    if (debug_full_erase) begin
      lock_n_nxt = 8'h00;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_n_r  <= 8'h00;
      sampled_r <= 1'b0;
    end else begin
      lock_n_r  <= lock_n_nxt;
      sampled_r <= sampled_nxt;
    end
  end

  // ===========================================================
  // Key sequence and supply monitor bits
  typedef enum logic [2:0] {
    FSG_KEY_IDLE  = 3'b001,
    FSG_KEY_HALF  = 3'b010,
    FSG_KEY_ARMED = 3'b100
  } fsg_key_t;
  fsg_key_t   key_r, key_nxt;
  logic       key_dead_r, key_dead_nxt;
  logic       mon_r, mon_nxt, src_r, src_nxt;
  logic       mod_req;
  assign mod_req = req.valid && !req.from_debug &&
                   (req.op == fsg_pkg::FSG_OP_WRITE || req.op == fsg_pkg::FSG_OP_ERASE);
  always_comb begin
    key_nxt      = key_r;
    key_dead_nxt = key_dead_r;
    if (key_wr && !key_dead_r) begin
      case (key_r)
        FSG_KEY_IDLE: begin
          if (key_data == fsg_pkg::KEY_FIRST) key_nxt = FSG_KEY_HALF;
          else key_dead_nxt = 1'b1;
        end
        FSG_KEY_HALF: begin
          if (key_data == fsg_pkg::KEY_SECOND) key_nxt = FSG_KEY_ARMED;
          else key_dead_nxt = 1'b1;
        end
        default: key_dead_nxt = 1'b1;
      endcase
    end
    if (mod_req) begin
      if (key_r != FSG_KEY_ARMED) key_dead_nxt = 1'b1;
      key_nxt = FSG_KEY_IDLE;
    end
    if (key_dead_nxt) key_nxt = FSG_KEY_IDLE;
    mon_nxt = supply_mon_clr ? 1'b0 : mon_r;
    src_nxt = supply_src_clr ? 1'b0 : src_r;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_r      <= FSG_KEY_IDLE;
      key_dead_r <= 1'b0;
    end else begin
      key_r      <= key_nxt;
      key_dead_r <= key_dead_nxt;
    end
    if (por_rst) begin
      mon_r <= fsg_pkg::SUPPLY_MON_RST;
      src_r <= fsg_pkg::SUPPLY_SRC_RST;
    end else begin
      mon_r <= mon_nxt;
      src_r <= src_nxt;
    end
  end

  // ===========================================================
  // Access decision
  logic [5:0] a_pg, pc_pg;
  logic       any_lock, a_locked, pc_locked, a_lockpg, a_resv, a_scr, pc_scr;
  logic       bad, deny_fw, enables_ok;
  fsg_pkg::fsg_resp_t resp_nxt;
  logic       fer_nxt, fflag_nxt, stall_nxt;
  assign a_pg      = req.addr[fsg_pkg::PAGE_MSB:fsg_pkg::PAGE_LSB];
  assign pc_pg     = req.pc[fsg_pkg::PAGE_MSB:fsg_pkg::PAGE_LSB];
  assign any_lock  = (lock_n_r != 8'h00);
  assign a_lockpg  = (a_pg == fsg_pkg::LOCK_PAGE_IDX);
  assign a_resv    = (req.addr >= fsg_pkg::RESERVED_BASE) && (req.addr != fsg_pkg::PART_ID_ADDR);
  assign a_scr     = scratchpad_select && (req.addr <= fsg_pkg::SCRATCH_LAST);
  assign pc_scr    = 1'b0;
  assign a_locked  = a_scr ? (lock_n_r >= {2'b00, fsg_pkg::LOCK_PAGE_IDX})
                           : ({2'b00, a_pg} < lock_n_r);
  assign pc_locked = ({2'b00, pc_pg} < lock_n_r) ||
                     (any_lock && pc_pg == fsg_pkg::LOCK_PAGE_IDX) || pc_scr;
  assign enables_ok = (req.op == fsg_pkg::FSG_OP_WRITE) ? program_write_enable
                    : (program_write_enable && program_erase_enable);
  always_comb begin
    bad = 1'b0;
    if (a_resv) bad = 1'b1;
    else if (req.op == fsg_pkg::FSG_OP_ERASE && !a_scr && a_lockpg) begin
      bad = !req.from_debug || any_lock;
    end else if (req.op == fsg_pkg::FSG_OP_WRITE && !a_scr && req.addr == fsg_pkg::LOCK_BYTE_ADDR &&
                 lock_byte_in != fsg_pkg::LOCK_BYTE_ERASED) begin
      bad = 1'b1;
    end else if (!a_scr && a_lockpg && any_lock) begin
      bad = req.from_debug || !pc_locked;
    end else if (a_locked) begin
      bad = req.from_debug || !pc_locked;
    end
    deny_fw = bad || (mod_req && (!mon_r || !src_r)) ||
              (mod_req && (key_r != FSG_KEY_ARMED || key_dead_r));
    resp_nxt = '0;
    fer_nxt  = 1'b0;
    if (req.valid) begin
      resp_nxt.done = 1'b1;
      if (req.op == fsg_pkg::FSG_OP_READ && !req.code_move && !req.from_debug) begin
        resp_nxt.permit  = 1'b1;
        resp_nxt.to_external_data_ram = 1'b1;
      end else if (req.op == fsg_pkg::FSG_OP_WRITE && !req.from_debug && !program_write_enable) begin
        resp_nxt.permit  = 1'b1;
        resp_nxt.to_external_data_ram = 1'b1;
      end else if (req.from_debug) begin
        resp_nxt.ignored    = bad;
        resp_nxt.permit     = !bad;
        resp_nxt.to_flash   = !bad && !a_scr;
        resp_nxt.to_scratch = !bad && a_scr;
      end else if (req.op == fsg_pkg::FSG_OP_FETCH) begin
        resp_nxt.permit   = 1'b1;
        resp_nxt.to_flash = 1'b1;
      end else if (mod_req && !enables_ok) begin
        resp_nxt.ignored = 1'b1;
      end else if (deny_fw) begin
        fer_nxt = 1'b1;
      end else begin
        resp_nxt.permit     = 1'b1;
        resp_nxt.to_flash   = !a_scr;
        resp_nxt.to_scratch = a_scr;
      end
    end
    fflag_nxt = fer_nxt ? 1'b1 : (flash_error_clr ? 1'b0 : flash_error_flag);
    stall_nxt = flash_busy;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resp              <= '0;
      flash_error_reset <= 1'b0;
      cpu_stall         <= 1'b0;
    end else begin
      resp              <= resp_nxt;
      flash_error_reset <= fer_nxt;
      cpu_stall         <= stall_nxt;
    end
    if (por_rst) flash_error_flag <= fsg_pkg::FLASH_ERR_RST;
    else flash_error_flag <= fflag_nxt;
  end

  // ===========================================================
  // Status outputs
  always_ff @(posedge clk) begin
    part_id       <= fsg_pkg::PART_ID_CODE;
    supply_mon_en <= mon_r;
    supply_src_en <= src_r;
    key_armed     <= (key_r == FSG_KEY_ARMED) && !key_dead_r;
    lock_count    <= lock_n_r;
  end

  // ===========================================================
  // Assertions
  a_debug_no_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && req.from_debug) |=> !flash_error_reset) else $error("debug access caused reset");
  a_err_sets_flag: assert property (@(posedge clk) disable iff (sys_rst || por_rst)
    flash_error_reset |=> flash_error_flag) else $error("flag not set after error");
  a_supply_off_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (mod_req && enables_ok && !mon_r) |=> flash_error_reset) else $error("supply off no reset");
  a_resv_fw_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && req.code_move && req.op == fsg_pkg::FSG_OP_READ && a_resv)
    |=> flash_error_reset) else $error("reserved read no reset");
  a_external_data_ram_read: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && !req.code_move && req.op == fsg_pkg::FSG_OP_READ)
    |=> resp.to_external_data_ram && !resp.to_flash) else $error("data read reached flash");
  a_stall_follows: assert property (@(posedge clk) disable iff (sys_rst)
    flash_busy |=> cpu_stall) else $error("no stall while busy");
  a_lock_erase_fw: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && req.op == fsg_pkg::FSG_OP_ERASE && enables_ok && a_lockpg && !a_scr)
    |=> flash_error_reset) else $error("lock page erase allowed");
  a_fetch_no_scratch: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && req.op == fsg_pkg::FSG_OP_FETCH) |=> !resp.to_scratch) else $error("fetch from scratchpad");
  a_full_erase: assert property (@(posedge clk) disable iff (sys_rst)
    (debug_full_erase && sampled_r) |=> ##1 lock_count == 8'h00) else $error("full erase kept lock");

  // ===========================================================
  // Multi-step behaviours
  sequence s_reset_release;
    sys_rst ##1 (!sys_rst && !debug_full_erase);
  endsequence
  sequence s_key_second;
    key_wr && !key_dead_r && !mod_req && key_r == FSG_KEY_HALF && key_data == fsg_pkg::KEY_SECOND;
  endsequence
  a_lock_sampled: assert property (@(posedge clk)
    s_reset_release
    |=> (lock_n_r == ~$past(lock_byte_in))) else $error("lock byte not sampled");
  a_lock_held: assert property (@(posedge clk) disable iff (sys_rst)
    (sampled_r && !debug_full_erase)
    |=> $stable(lock_n_r)) else $error("lock count changed in run");
  a_key_arms: assert property (@(posedge clk) disable iff (sys_rst)
    s_key_second
    |=> ##1 key_armed) else $error("key pair did not arm");
  a_bad_key_dead: assert property (@(posedge clk) disable iff (sys_rst)
    (key_wr && !key_dead_r && key_r == FSG_KEY_IDLE && key_data != fsg_pkg::KEY_FIRST)
    |=> key_dead_r) else $error("bad key kept modify");
  a_unarmed_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (mod_req && enables_ok && key_r != FSG_KEY_ARMED)
    |=> flash_error_reset) else $error("unarmed modify allowed");
  a_erase_needs_ee: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && req.op == fsg_pkg::FSG_OP_ERASE && !program_erase_enable)
    |=> (resp.ignored && !flash_error_reset)) else $error("erase without erase enable");
  a_locked_dbg: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && req.from_debug && a_locked)
    |=> resp.ignored) else $error("debug reached locked page");
  a_locked_fw: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && req.code_move && req.op == fsg_pkg::FSG_OP_READ && a_locked && !a_resv &&
     !a_lockpg && !pc_locked) |=> flash_error_reset) else $error("unlocked code read locked page");
  a_lockpg_fw: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && req.code_move && req.op == fsg_pkg::FSG_OP_READ && a_lockpg && any_lock &&
     !pc_locked) |=> flash_error_reset) else $error("lock page read allowed");
  a_resv_dbg: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && req.from_debug && a_resv)
    |=> resp.ignored) else $error("debug reached reserved area");
  a_lockbyte_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && req.op == fsg_pkg::FSG_OP_WRITE && program_write_enable &&
     req.addr == fsg_pkg::LOCK_BYTE_ADDR && lock_byte_in != fsg_pkg::LOCK_BYTE_ERASED) |=> flash_error_reset)
    else $error("lock byte rewritten");
  a_scratch_lock: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && req.from_debug && a_scr && lock_n_r >= {2'b00, fsg_pkg::LOCK_PAGE_IDX})
    |=> resp.ignored) else $error("locked scratchpad reached");
  a_scratch_map: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && req.code_move && req.op == fsg_pkg::FSG_OP_READ && a_scr && !a_locked)
    |=> (resp.to_scratch && !resp.to_flash)) else $error("scratchpad not mapped");
  a_flag_holds: assert property (@(posedge clk) disable iff (por_rst)
    (flash_error_flag && !flash_error_clr)
    |=> flash_error_flag) else $error("error flag lost");
  a_src_off_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (mod_req && enables_ok && !src_r)
    |=> flash_error_reset) else $error("source off no reset");
  a_por_enables: assert property (@(posedge clk)
    por_rst
    |=> ##1 (supply_mon_en && supply_src_en)) else $error("monitor not enabled at power-on");
  a_stall_release: assert property (@(posedge clk) disable iff (sys_rst)
    !flash_busy
    |=> !cpu_stall) else $error("stall without busy");
  a_external_data_ram_no_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (req.valid && !req.from_debug && !req.code_move && req.op == fsg_pkg::FSG_OP_READ)
    |=> !flash_error_reset) else $error("data read caused reset");
endmodule : fsg_guard

/* tb/flash_security_guard_tb.sv */
// Self-checking bench for the flash security guard.
// Assumes the flash model supplies the lock byte and busy level.
module flash_security_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic sel, dbg, cm; fsg_pkg::fsg_op_t op; logic [15:0] addr, pc; logic [4:0] exp;
  } fsg_row_t;
  localparam fsg_pkg::fsg_op_t RD = fsg_pkg::FSG_OP_READ;
  localparam fsg_pkg::fsg_op_t FE = fsg_pkg::FSG_OP_FETCH;
  logic clk, sys_rst, por_rst, scratchpad_select, program_write_enable, program_erase_enable;
  logic supply_mon_clr, supply_src_clr, key_wr, flash_error_clr, flash_busy, debug_full_erase, load;
  logic [7:0] key_data, lock_byte_in, load_val, part_id, lock_count, vec;
  logic flash_error_reset, flash_error_flag, cpu_stall, supply_mon_en, supply_src_en, key_armed;
  fsg_pkg::fsg_req_t  req;
  fsg_pkg::fsg_resp_t resp;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Lock byte 0xfd: pages 0 and 1 locked; row exp is flash,scratch,external_data_ram,ignored,reset
  fsg_row_t rows [15] = '{
    '{0,0,1,RD,16'h1000,16'h1000,5'h10}, '{0,0,1,RD,16'h0400,16'h2000,5'h01},
    '{0,0,1,RD,16'h0400,16'h0100,5'h10}, '{0,1,1,RD,16'h0400,16'h0000,5'h02},
    '{0,1,1,RD,16'h1000,16'h0000,5'h10}, '{0,0,1,RD,16'hfbff,16'h2000,5'h01},
    '{0,1,1,RD,16'hf800,16'h0000,5'h02}, '{0,0,1,RD,16'hfc00,16'h0100,5'h01},
    '{0,1,1,RD,16'hfd00,16'h0000,5'h02}, '{0,0,1,RD,16'hfffe,16'h2000,5'h10},
    '{0,0,0,RD,16'h1000,16'h1000,5'h04}, '{0,1,0,fsg_pkg::FSG_OP_ERASE,16'hf800,16'h0000,5'h02},
    '{0,0,0,FE,16'h1000,16'h1000,5'h10}, '{1,0,1,RD,16'h0100,16'h2000,5'h08},
    '{1,0,0,FE,16'h0100,16'h0100,5'h10}};
  assign vec = {3'h0, resp.to_flash, resp.to_scratch, resp.to_external_data_ram, resp.ignored, flash_error_reset};
  always #4 clk = ~clk;
  fsg_guard DUT (.clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .scratchpad_select(scratchpad_select),
    .program_write_enable(program_write_enable), .program_erase_enable(program_erase_enable),
    .supply_mon_clr(supply_mon_clr), .supply_src_clr(supply_src_clr), .key_wr(key_wr), .key_data(key_data),
    .flash_error_clr(flash_error_clr), .lock_byte_in(lock_byte_in), .flash_busy(flash_busy),
    .debug_full_erase(debug_full_erase), .req(req), .resp(resp), .part_id(part_id),
    .flash_error_reset(flash_error_reset), .flash_error_flag(flash_error_flag), .cpu_stall(cpu_stall),
    .supply_mon_en(supply_mon_en), .supply_src_en(supply_src_en), .key_armed(key_armed),
    .lock_count(lock_count));
  fsg_flash_model u_flash (.clk(clk), .load(load), .load_val(load_val), .debug_full_erase(debug_full_erase),
    .req(req), .resp(resp), .lock_byte(lock_byte_in), .flash_busy(flash_busy));
  // ==========================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic access(input fsg_row_t r);
    @(negedge clk);
    scratchpad_select = r.sel;
    req = '{1'b1, r.dbg, r.cm, r.op, r.addr, r.pc};
    @(negedge clk);
    req.valid = 1'b0;
  endtask : access
  task automatic go(input logic dbg, input fsg_pkg::fsg_op_t op, input logic [15:0] a);
    access('{1'b0, dbg, 1'b0, op, a, a, 5'h00});
  endtask : go
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic keys;
    key_data = fsg_pkg::KEY_FIRST;
    pulse(key_wr);
    key_data = fsg_pkg::KEY_SECOND;
    pulse(key_wr);
  endtask : keys
  task automatic do_reset(input logic por);
    sys_rst = 1'b1;
    por_rst = por;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    por_rst = 1'b0;
    load = 1'b0;
    repeat (3) @(negedge clk);
  endtask : do_reset
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ==========================================
  // Sequence
  initial begin
    {clk, scratchpad_select, program_write_enable, program_erase_enable, supply_mon_clr} = '0;
    {supply_src_clr, key_wr, flash_error_clr, debug_full_erase, key_data} = '0;
    req = '0;
    load = 1'b1;
    load_val = 8'hfd;
    do_reset(1'b1);
    chk(lock_count, 8'h02, "lock count");
    chk({6'h0, supply_mon_en, supply_src_en}, 8'h03, "monitor en");
    chk(part_id, fsg_pkg::PART_ID_CODE, "part id");
    foreach (rows[i]) begin
      access(rows[i]);
      chk(vec, {3'h0, rows[i].exp}, "row");
    end
    program_write_enable = 1'b1;
    keys();
    @(negedge clk);
    chk({7'h0, key_armed}, 8'h01, "armed");
    go(1'b0, fsg_pkg::FSG_OP_WRITE, 16'h2000);
    chk({1'b0, resp.done, resp.permit, vec[4:0]}, 8'h70, "write");
    @(negedge clk);
    chk({7'h0, key_armed}, 8'h00, "disarmed");
    @(negedge clk);
    chk({7'h0, cpu_stall}, 8'h01, "stall");
    repeat (4) @(negedge clk);
    keys();
    go(1'b0, fsg_pkg::FSG_OP_ERASE, 16'h2000);
    chk(vec, 8'h02, "erase no ee");
    do_reset(1'b0);
    pulse(supply_mon_clr);
    keys();
    go(1'b0, fsg_pkg::FSG_OP_WRITE, 16'h2000);
    chk(vec[0], 1'b1, "monitor off");
    @(negedge clk);
    chk({7'h0, flash_error_flag}, 8'h01, "error flag");
    pulse(flash_error_clr);
    chk({7'h0, flash_error_flag}, 8'h00, "flag clear");
    load_val = 8'h00;
    pulse(load);
    repeat (2) @(negedge clk);
    chk(lock_count, 8'h02, "lock held");
    do_reset(1'b1);
    chk(lock_count, 8'hff, "lock sampled");
    pulse(debug_full_erase);
    @(negedge clk);
    chk(lock_count, 8'h00, "full erase");
    go(1'b1, fsg_pkg::FSG_OP_ERASE, 16'hf800);
    chk(vec, 8'h10, "debug erase");
    conclude();
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule : flash_security_guard_tb

/* tb/fsg_flash_model.sv */
// Flash array partner model: lock byte storage and flash busy timing.
// Assumes the guard's request and verdict are seen at its ports.
module fsg_flash_model (
  // Clock
  input  wire logic               clk,
  // Control
  input  wire logic               load,
  input  wire logic [7:0]         load_val,
  input  wire logic               debug_full_erase,
  input  wire fsg_pkg::fsg_req_t  req,
  input  wire fsg_pkg::fsg_resp_t resp,
  // Array state
  output logic [7:0]              lock_byte,
  output logic                    flash_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       mod_r;
  logic [2:0] busy_cnt_r;
  initial begin
    lock_byte = 8'hff;
    busy_cnt_r = 3'h0;
    mod_r = 1'b0;
  end
  always @(posedge clk) begin
    mod_r <= req.valid && (req.op == fsg_pkg::FSG_OP_WRITE || req.op == fsg_pkg::FSG_OP_ERASE);
    if (debug_full_erase) lock_byte <= 8'hff;
    else if (load) lock_byte <= load_val;
    if (mod_r && resp.done && resp.permit && resp.to_flash) busy_cnt_r <= 3'h4;
    else if (busy_cnt_r != 3'h0) busy_cnt_r <= busy_cnt_r - 3'h1;
  end
  assign flash_busy = busy_cnt_r != 3'h0;
endmodule : fsg_flash_model
